// ==== ptwlm_far_side.sv ====
// far side of the timer: free timer clock pin and external source levels
// assumes the bench changes source levels rarely, far slower than the timer clock
`timescale 1ns/10ps
`default_nettype none

module ptwlm_far_side #(
   parameter int HALF_NS = 200
) (
   // control from the bench
   input  wire logic       run_i,
   input  wire logic [7:0] src_level_i,
   // pins toward the timer
   output var  logic       timer_clk_o,
   output logic      [7:0] ext_source_o
);
   // the timer clock pin is an oscillator and runs free; odd start phase
   // keeps its edges away from the system clock edges
   initial begin
      timer_clk_o = 1'b0;
      #13;
      forever begin
         #(HALF_NS) timer_clk_o = run_i & ~timer_clk_o;
      end
   end
   assign ext_source_o = src_level_i;
endmodule : ptwlm_far_side
`default_nettype wire

// ==== ptwlm_pkg.sv ====
// constants, field layouts and types for the period timer with limit modes
// assumes one 25 MHz system clock and a plain register port with 8-bit data

package ptwlm_pkg;

   // ******************************************************************
   // widths
   // ******************************************************************
   localparam int DATA_W   = 8;
   localparam int ADDR_W   = 8;
   localparam int NUM_SRC  = 8;
   localparam int SRC_W    = 3;
   localparam int SYNC_W   = NUM_SRC + 2;
   localparam int TCLK_IDX = NUM_SRC;
   localparam int DBG_IDX  = NUM_SRC + 1;

   // ******************************************************************
   // register offsets
   // ******************************************************************
   localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_LIMIT  = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_RSTSRC = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h05;

   // ******************************************************************
   // reset values and status bit positions
   // ******************************************************************
   localparam logic [DATA_W-1:0] COUNT_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] PERIOD_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] READ_ZERO    = 8'h00;
   localparam int                STAT_FLAG    = 0;
   localparam int                STAT_IE      = 1;
   localparam int                STAT_ST_LO   = 2;
   localparam int                STAT_ST_HI   = 3;

   // ******************************************************************
   // mode field: class in [4:3], behaviour in [2:0]
   // ******************************************************************
   localparam logic [1:0] CLS_FREE    = 2'h0;
   localparam logic [1:0] CLS_ONESHOT = 2'h1;
   localparam logic [1:0] CLS_MONO    = 2'h2;
   localparam logic [2:0] SUB_SW      = 3'h0;
   localparam logic [2:0] SUB_GATE_HI = 3'h1;
   localparam logic [2:0] SUB_GATE_LO = 3'h2;
   localparam logic [2:0] SUB_ANY     = 3'h3;
   localparam logic [2:0] SUB_RISE    = 3'h4;
   localparam logic [2:0] SUB_FALL    = 3'h5;
   localparam logic [2:0] SUB_LOW     = 3'h6;
   localparam logic [2:0] SUB_HIGH    = 3'h7;

   // ******************************************************************
   // register layouts
   // ******************************************************************
   typedef struct packed {
      logic       on;
      logic [2:0] presc;
      logic [3:0] post;
   } ptwlm_ctrl_t;

   typedef struct packed {
      logic       prescaler_output_sync;
      logic       enable_clock_sync;
      logic [1:0] cls;
      logic [2:0] sub;
   } ptwlm_limit_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARM  = 2'b01,
      ST_RUN  = 2'b11,
      ST_DONE = 2'b10
   } ptwlm_state_t;

endpackage : ptwlm_pkg

// ==== ptwlm_timer.sv ====
// 8-bit period timer with prescaler, postscaler and limit modes
// assumes timer clock, reset sources and debug arrive asynchronously on pins
//
// The register addresses and the address-and-strobe port were chosen for this implementation.

`timescale 1ns/10ps
`default_nettype none

module ptwlm_timer (
   // clock and reset
   input  wire logic                          ref_clk_i,
   input  wire logic                          reset_i,
   // register port
   input  wire logic [ptwlm_pkg::ADDR_W-1:0]  reg_addr_i,
   input  wire logic [ptwlm_pkg::DATA_W-1:0]  reg_wdata_i,
   input  wire logic                          reg_write_i,
   input  wire logic                          reg_read_i,
   output logic      [ptwlm_pkg::DATA_W-1:0]  reg_rdata_o,
   // pins
   input  wire logic                          timer_clk_i,
   input  wire logic [ptwlm_pkg::NUM_SRC-1:0] ext_source_i,
   input  wire logic                          debug_mode_i,
   // events
   output logic                               postscaled_pulse_o,
   output logic                               match_irq_o
);

   // ******************************************************************
   // registers
   // ******************************************************************
   logic [ptwlm_pkg::DATA_W-1:0] count;
   logic [ptwlm_pkg::DATA_W-1:0] period;
   ptwlm_pkg::ptwlm_ctrl_t       ctrl;
   ptwlm_pkg::ptwlm_limit_t      limit;
   logic [ptwlm_pkg::SRC_W-1:0]  src_sel;
   logic                         flag;
   logic                         irq_en;
   ptwlm_pkg::ptwlm_state_t      state;
   ptwlm_pkg::ptwlm_state_t      next_state;

   logic count_wr;
   logic period_wr;
   logic ctrl_wr;
   logic limit_wr;
   logic src_wr;
   logic status_wr;

   assign count_wr  = reg_write_i && (reg_addr_i == ptwlm_pkg::ADDR_COUNT);
   assign period_wr = reg_write_i && (reg_addr_i == ptwlm_pkg::ADDR_PERIOD);
   assign ctrl_wr   = reg_write_i && (reg_addr_i == ptwlm_pkg::ADDR_CTRL);
   assign limit_wr  = reg_write_i && (reg_addr_i == ptwlm_pkg::ADDR_LIMIT);
   assign src_wr    = reg_write_i && (reg_addr_i == ptwlm_pkg::ADDR_RSTSRC);
   assign status_wr = reg_write_i && (reg_addr_i == ptwlm_pkg::ADDR_STATUS);

   // ******************************************************************
   // pin synchronisers
   // ******************************************************************
   logic [ptwlm_pkg::SYNC_W-1:0] raw_in;
   logic [ptwlm_pkg::SYNC_W-1:0] sync_a;
   logic [ptwlm_pkg::SYNC_W-1:0] sync_b;

   assign raw_in = {debug_mode_i, timer_clk_i, ext_source_i};

   genvar gi;
   generate
      for (gi = 0; gi < ptwlm_pkg::SYNC_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   logic tclk_s;
   logic tclk_d;
   logic tclk_tick;
   logic debug_s;
   logic ers_v;
   logic ers_p;
   logic ers_rise;
   logic ers_fall;

   assign tclk_s  = sync_b[ptwlm_pkg::TCLK_IDX];
   assign debug_s = sync_b[ptwlm_pkg::DBG_IDX];

   // debug freezes the source
   // the selected source is frozen in debug so no edge or level change gets through
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         tclk_d <= 1'b0;
         ers_v  <= 1'b0;
         ers_p  <= 1'b0;
      end else begin
         tclk_d <= tclk_s;
         ers_p  <= ers_v;
         if (!debug_s) begin
            ers_v <= sync_b[src_sel];
         end
      end
   end

   assign tclk_tick = tclk_s && !tclk_d;
   assign ers_rise  = ers_v && !ers_p;
   assign ers_fall  = !ers_v && ers_p;

   // ******************************************************************
   // mode decode
   // ******************************************************************
   // mode field decode
   function automatic logic f_start(input logic [2:0] sub, input logic rise,
                                    input logic fall);
      case (sub)
         ptwlm_pkg::SUB_GATE_HI, ptwlm_pkg::SUB_RISE, ptwlm_pkg::SUB_LOW: begin
            f_start = rise;
         end
         ptwlm_pkg::SUB_GATE_LO, ptwlm_pkg::SUB_FALL, ptwlm_pkg::SUB_HIGH: begin
            f_start = fall;
         end
         ptwlm_pkg::SUB_ANY: begin
            f_start = rise || fall;
         end
         default: begin
            f_start = 1'b0;
         end
      endcase
   endfunction : f_start

   function automatic logic f_reset(input logic [2:0] sub, input logic rise,
                                    input logic fall, input logic lvl,
                                    input logic any_ok);
      case (sub)
         ptwlm_pkg::SUB_ANY: begin
            f_reset = any_ok && (rise || fall);
         end
         ptwlm_pkg::SUB_RISE: begin
            f_reset = rise;
         end
         ptwlm_pkg::SUB_FALL: begin
            f_reset = fall;
         end
         ptwlm_pkg::SUB_LOW: begin
            f_reset = !lvl;
         end
         ptwlm_pkg::SUB_HIGH: begin
            f_reset = lvl;
         end
         default: begin
            f_reset = 1'b0;
         end
      endcase
   endfunction : f_reset

   logic is_free;
   logic is_oneshot;
   logic is_mono;
   logic start_evt;
   logic reset_evt;
   logic gate_ok;
   logic on_eff;
   logic on_tsync;

   assign is_free    = (limit.cls == ptwlm_pkg::CLS_FREE);
   assign is_oneshot = (limit.cls == ptwlm_pkg::CLS_ONESHOT);
   assign is_mono    = (limit.cls == ptwlm_pkg::CLS_MONO);
   assign start_evt  = f_start(limit.sub, ers_rise, ers_fall);

   // selected source drives start and reset
   assign reset_evt = on_eff && (state != ptwlm_pkg::ST_IDLE) && (
      (is_free && f_reset(limit.sub, ers_rise, ers_fall, ers_v, 1'b1)) ||
      (is_oneshot && f_reset(limit.sub, ers_rise, ers_fall, ers_v, 1'b0)));

   assign gate_ok = !(is_free && (limit.sub == ptwlm_pkg::SUB_GATE_HI) && !ers_v) &&
                    !(is_free && (limit.sub == ptwlm_pkg::SUB_GATE_LO) && ers_v);

   // enable retimed on timer clock
   // the edge that takes the enable is not counted, because run_ok saw the old value
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         on_tsync <= 1'b0;
      end else if (!ctrl.on) begin
         on_tsync <= 1'b0;
      end else if (tclk_tick) begin
         on_tsync <= 1'b1;
      end
   end

   // enable taken directly unless enable_clock_sync picks the retimed copy
   // switching off acts at once in both options; only switching on waits for the edge
   assign on_eff = limit.enable_clock_sync ? (on_tsync && ctrl.on) : ctrl.on;

   // ******************************************************************
   // run state
   // ******************************************************************
   logic period_evt;

   always_comb begin
      next_state = state;
      case (state)
         ptwlm_pkg::ST_IDLE: begin
            if (is_free || (is_oneshot && (limit.sub == ptwlm_pkg::SUB_SW))) begin
               next_state = ptwlm_pkg::ST_RUN;
            end else begin
               next_state = ptwlm_pkg::ST_ARM;
            end
         end
         ptwlm_pkg::ST_ARM: begin
            if (start_evt) begin
               next_state = ptwlm_pkg::ST_RUN;
            end
         end
         ptwlm_pkg::ST_RUN: begin
            if (period_evt && !is_free) begin
               next_state = ptwlm_pkg::ST_DONE;
            end
         end
         ptwlm_pkg::ST_DONE: begin
            if (is_mono && start_evt) begin
               next_state = ptwlm_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = ptwlm_pkg::ST_IDLE;
         end
      endcase
      if (!on_eff) begin
         next_state = ptwlm_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state <= ptwlm_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ******************************************************************
   // prescaler
   // ******************************************************************
   logic       run_ok;
   logic       scaler_clr;
   logic [6:0] presc_cnt;
   logic [6:0] presc_mask;
   logic [7:0] presc_ratio;
   logic       presc_raw;
   logic       presc_q;
   logic       timer_tick;

   assign run_ok = (state == ptwlm_pkg::ST_RUN) && on_eff && gate_ok;

   assign scaler_clr = count_wr || ctrl_wr || reset_evt;

   // ratio is a power of two
   assign presc_ratio = 8'h01 << ctrl.presc;
   assign presc_mask  = presc_ratio[6:0] - 7'h01;
   assign presc_raw   = tclk_tick && run_ok && (presc_cnt == presc_mask);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i || scaler_clr) begin
         presc_cnt <= 7'h00;
      end else if (tclk_tick && run_ok) begin
         presc_cnt <= (presc_cnt == presc_mask) ? 7'h00 : presc_cnt + 7'h01;
      end
   end

   // retimed prescaler output
   // retiming costs a cycle; fine only while the tick rate stays below ours
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         presc_q <= 1'b0;
      end else begin
         presc_q <= presc_raw && run_ok;
      end
   end

   assign timer_tick = (limit.prescaler_output_sync ? presc_q : presc_raw) && run_ok;

   // ******************************************************************
   // count and period
   // ******************************************************************
   // match is seen on the tick that clears the count
   assign period_evt = timer_tick && (count == period) && !reset_evt && !count_wr;

   // control writes do not touch the count
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         count <= ptwlm_pkg::COUNT_RESET;
      end else if (count_wr) begin
         count <= reg_wdata_i;
      end else if (reset_evt) begin
         count <= ptwlm_pkg::COUNT_RESET;
      end else if (timer_tick) begin
         count <= (count == period) ? ptwlm_pkg::COUNT_RESET : count + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         period <= ptwlm_pkg::PERIOD_RESET;
      end else if (period_wr) begin
         period <= reg_wdata_i;
      end
   end

   // ******************************************************************
   // postscaler and output pulse
   // ******************************************************************
   logic [3:0] post_cnt;
   logic       post_hit;
   logic       post_fire;
   logic       pulse_q;

   // single-shot modes fire on the first period
   assign post_hit  = !is_free || (post_cnt == ctrl.post);
   assign post_fire = period_evt && post_hit;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i || scaler_clr) begin
         post_cnt <= 4'h0;
      end else if (period_evt) begin
         post_cnt <= post_hit ? 4'h0 : post_cnt + 4'h1;
      end
   end

   // one timer clock wide pulse
   // held until the next timer input edge, so its width follows that clock
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pulse_q <= 1'b0;
      end else if (post_fire) begin
         pulse_q <= 1'b1;
      end else if (tclk_tick) begin
         pulse_q <= 1'b0;
      end
   end

   assign postscaled_pulse_o = pulse_q;

   // ******************************************************************
   // control, config and status registers
   // ******************************************************************
   // one-shot match drops enable
   // a software write in the same cycle is honoured over the hardware clear
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ctrl <= '0;
      end else if (ctrl_wr) begin
         ctrl <= ptwlm_pkg::ptwlm_ctrl_t'(reg_wdata_i);
      end else if (period_evt && is_oneshot) begin
         ctrl.on <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         limit   <= '0;
         src_sel <= '0;
         irq_en  <= 1'b0;
      end else begin
         if (limit_wr) begin
            limit <= ptwlm_pkg::ptwlm_limit_t'(reg_wdata_i[6:0]);
         end
         if (src_wr) begin
            src_sel <= reg_wdata_i[ptwlm_pkg::SRC_W-1:0];
         end
         if (status_wr) begin
            irq_en <= reg_wdata_i[ptwlm_pkg::STAT_IE];
         end
      end
   end

   // flag set on the system clock
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         flag <= 1'b0;
      end else if (post_fire) begin
         flag <= 1'b1;
      end else if (status_wr && !reg_wdata_i[ptwlm_pkg::STAT_FLAG]) begin
         flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         match_irq_o <= 1'b0;
      end else begin
         match_irq_o <= flag && irq_en;
      end
   end

   // ******************************************************************
   // read port
   // ******************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !reg_read_i) begin
         reg_rdata_o <= ptwlm_pkg::READ_ZERO;
      end else begin
         case (reg_addr_i)
            ptwlm_pkg::ADDR_COUNT:  reg_rdata_o <= count;
            ptwlm_pkg::ADDR_PERIOD: reg_rdata_o <= period;
            ptwlm_pkg::ADDR_CTRL:   reg_rdata_o <= ctrl;
            ptwlm_pkg::ADDR_LIMIT:  reg_rdata_o <= {1'b0, limit};
            ptwlm_pkg::ADDR_RSTSRC: reg_rdata_o <= {5'h00, src_sel};
            ptwlm_pkg::ADDR_STATUS: reg_rdata_o <= {4'h0, state, irq_en, flag};
            default:                reg_rdata_o <= ptwlm_pkg::READ_ZERO;
         endcase
      end
   end

   // ******************************************************************
   // assertions
   // ******************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_fire;
      post_fire;
   endsequence

   sequence s_pulse_hold;
      pulse_q && !tclk_tick;
   endsequence

   a_match_wrap: assert property (period_evt |=> count == 8'h00)
      else $error("count did not wrap after match");
   a_idle_hold: assert property (!on_eff && !count_wr |=> $stable(count))
      else $error("count moved while disabled");
   a_pulse_start: assert property (s_fire |=> pulse_q && post_cnt == 4'h0)
      else $error("no pulse or postscaler not cleared");
   a_pulse_width: assert property (s_pulse_hold ##1 !post_fire |-> pulse_q)
      else $error("pulse dropped before timer edge");
   a_oneshot_stop: assert property (period_evt && is_oneshot && !ctrl_wr
                                    |=> !ctrl.on ##1 state == ptwlm_pkg::ST_IDLE)
      else $error("one-shot did not stop");
   a_scaler_clear: assert property (count_wr |=> presc_cnt == 7'h00 && post_cnt == 4'h0)
      else $error("scalers not cleared on count write");
   a_ctrl_keep: assert property (ctrl_wr && !timer_tick && !reset_evt |=> $stable(count))
      else $error("control write changed count");
   a_flag_sets: assert property (s_fire |=> flag ##1 (match_irq_o == $past(irq_en)))
      else $error("flag or interrupt not raised");
   a_debug_freeze: assert property (debug_s |=> $stable(ers_v))
      else $error("source moved during debug");
   a_gate_halt: assert property (!gate_ok && !count_wr && !reset_evt
                                 |=> $stable(count))
      else $error("count moved with gate inactive");

endmodule : ptwlm_timer

`default_nettype wire

// ==== test_period_timer_with_limit_modes.sv ====
// self-checking bench for the period timer with limit modes
// assumes the timer clock is ten system cycles long and runs free
`timescale 1ns/10ps
`default_nettype none

module test_period_timer_with_limit_modes;
   localparam int TCLK_CYC = 10;
   logic       ref_clk_i, reset_i, reg_write_i, reg_read_i, debug_mode_i;
   logic       timer_clk_i, postscaled_pulse_o, match_irq_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, src_level, ext_source_i, v;
   int         fail_count, cmp_count, n, e;
   logic [7:0] per [3] = '{8'h02, 8'h00, 8'h00};
   logic [7:0] ctl [3] = '{8'h81, 8'h8F, 8'hF0};

   ptwlm_timer dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o), .timer_clk_i(timer_clk_i), .ext_source_i(ext_source_i),
      .debug_mode_i(debug_mode_i), .postscaled_pulse_o(postscaled_pulse_o),
      .match_irq_o(match_irq_o));
   ptwlm_far_side far (.run_i(1'b1), .src_level_i(src_level), .timer_clk_o(timer_clk_i),
      .ext_source_o(ext_source_i));

   // ******************************************************************
   // bus and compare tasks
   // ******************************************************************
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_n(input string what, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_n
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_write_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_read_i <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask : rd
   task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask : rdchk
   // cycles until the next rising edge of the postscaled pulse
   task automatic wait_rise(output int k);
      logic last;
      last = postscaled_pulse_o;
      k = 0;
      forever begin
         @(posedge ref_clk_i);
         #1;
         k++;
         if (postscaled_pulse_o === 1'b1 && last !== 1'b1) break;
         last = postscaled_pulse_o;
         if (k > 3000) begin
            chk("pulse_seen", 8'h01, 8'h00);
            stop_test();
         end
      end
   endtask : wait_rise

   // ******************************************************************
   // scenarios
   // ******************************************************************
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic test_registers();
      rdchk("count_reset", ptwlm_pkg::ADDR_COUNT, 8'h00);
      rdchk("period_reset", ptwlm_pkg::ADDR_PERIOD, 8'hFF);
      rdchk("ctrl_reset", ptwlm_pkg::ADDR_CTRL, 8'h00);
      wr(8'h06, 8'h5A);
      rdchk("unmapped", 8'h06, 8'h00);
      wr(ptwlm_pkg::ADDR_PERIOD, 8'hAA);
      rdchk("period_rw", ptwlm_pkg::ADDR_PERIOD, 8'hAA);
      $display("test registers done");
   endtask : test_registers
   task automatic test_free_running();
      wr(ptwlm_pkg::ADDR_STATUS, 8'h02);
      for (int i = 0; i < 3; i++) begin
         e = (per[i] + 1) * (ctl[i][3:0] + 1) * (1 << ctl[i][6:4]) * TCLK_CYC;
         wr(ptwlm_pkg::ADDR_PERIOD, per[i]);
         wr(ptwlm_pkg::ADDR_CTRL, ctl[i]);
         wait_rise(n);
         wait_rise(n);
         chk_n("pulse_interval", e, n);
      end
      repeat (3) @(posedge ref_clk_i);
      chk("irq_on", 8'h01, {7'h0, match_irq_o});
      wr(ptwlm_pkg::ADDR_CTRL, 8'h00);
      wr(ptwlm_pkg::ADDR_STATUS, 8'h02);
      rdchk("flag_clear", ptwlm_pkg::ADDR_STATUS, 8'h02);
      chk("irq_off", 8'h00, {7'h0, match_irq_o});
      wr(ptwlm_pkg::ADDR_COUNT, 8'h05);
      wr(ptwlm_pkg::ADDR_CTRL, 8'h01);
      repeat (40) @(posedge ref_clk_i);
      rdchk("count_kept", ptwlm_pkg::ADDR_COUNT, 8'h05);
      $display("test free running done");
   endtask : test_free_running
   task automatic test_sync();
      wr(ptwlm_pkg::ADDR_COUNT, 8'h00);
      // prescaler output runs at a tenth of our rate, so retiming is legal
      wr(ptwlm_pkg::ADDR_LIMIT, 8'h60);
      wr(ptwlm_pkg::ADDR_PERIOD, 8'h02);
      wr(ptwlm_pkg::ADDR_CTRL, 8'h81);
      wait_rise(n);
      wait_rise(n);
      chk_n("sync_interval", 3 * 2 * TCLK_CYC, n);
      wr(ptwlm_pkg::ADDR_CTRL, 8'h00);
      $display("test sync options done");
   endtask : test_sync
   task automatic test_one_shot();
      wr(ptwlm_pkg::ADDR_LIMIT, 8'h08);
      wr(ptwlm_pkg::ADDR_PERIOD, 8'h03);
      wr(ptwlm_pkg::ADDR_COUNT, 8'h00);
      wr(ptwlm_pkg::ADDR_CTRL, 8'h85);
      wait_rise(n);
      chk("oneshot_first", 8'h01, {7'h0, n <= 7 * TCLK_CYC});
      repeat (20) @(posedge ref_clk_i);
      rdchk("oneshot_off", ptwlm_pkg::ADDR_CTRL, 8'h05);
      rdchk("oneshot_count", ptwlm_pkg::ADDR_COUNT, 8'h00);
      rdchk("oneshot_state", ptwlm_pkg::ADDR_STATUS, 8'h03);
      $display("test one shot done");
   endtask : test_one_shot
   task automatic test_gate_reset();
      wr(ptwlm_pkg::ADDR_CTRL, 8'h00);
      wr(ptwlm_pkg::ADDR_RSTSRC, 8'h03);
      wr(ptwlm_pkg::ADDR_LIMIT, 8'h01);
      wr(ptwlm_pkg::ADDR_PERIOD, 8'hFF);
      wr(ptwlm_pkg::ADDR_CTRL, 8'h80);
      repeat (60) @(posedge ref_clk_i);
      rdchk("gate_shut", ptwlm_pkg::ADDR_COUNT, 8'h00);
      src_level <= 8'h08;
      repeat (80) @(posedge ref_clk_i);
      rd(ptwlm_pkg::ADDR_COUNT, v);
      chk("gate_open", 8'h01, {7'h0, v != 8'h00});
      wr(ptwlm_pkg::ADDR_LIMIT, 8'h07);
      repeat (40) @(posedge ref_clk_i);
      rdchk("level_reset", ptwlm_pkg::ADDR_COUNT, 8'h00);
      $display("test gate and reset done");
   endtask : test_gate_reset
   // rising-edge monostable; edges seen in debug must not start it
   task automatic test_mono_debug();
      wr(ptwlm_pkg::ADDR_CTRL, 8'h00);
      src_level <= 8'h00;
      wr(ptwlm_pkg::ADDR_LIMIT, 8'h11);
      wr(ptwlm_pkg::ADDR_PERIOD, 8'h03);
      wr(ptwlm_pkg::ADDR_CTRL, 8'h80);
      debug_mode_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      src_level <= 8'h08;
      repeat (60) @(posedge ref_clk_i);
      rdchk("debug_ignored", ptwlm_pkg::ADDR_COUNT, 8'h00);
      src_level <= 8'h00;
      repeat (8) @(posedge ref_clk_i);
      debug_mode_i <= 1'b0;
      repeat (60) @(posedge ref_clk_i);
      src_level <= 8'h08;
      wait_rise(n);
      chk("mono_first", 8'h01, {7'h0, n <= 7 * TCLK_CYC});
      repeat (20) @(posedge ref_clk_i);
      rdchk("mono_on_kept", ptwlm_pkg::ADDR_CTRL, 8'h80);
      rdchk("mono_done", ptwlm_pkg::ADDR_STATUS, 8'h0B);
      src_level <= 8'h00;
      repeat (60) @(posedge ref_clk_i);
      src_level <= 8'h08;
      wait_rise(n);
      chk("mono_restart", 8'h01, {7'h0, n <= 7 * TCLK_CYC});
      $display("test monostable and debug done");
   endtask : test_mono_debug
   task automatic test_reset();
      wr(ptwlm_pkg::ADDR_PERIOD, 8'h33);
      reset_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rdchk("period_again", ptwlm_pkg::ADDR_PERIOD, 8'hFF);
      rdchk("count_again", ptwlm_pkg::ADDR_COUNT, 8'h00);
      rdchk("ctrl_again", ptwlm_pkg::ADDR_CTRL, 8'h00);
      $display("test reset done");
   endtask : test_reset
   initial begin
      reset_i = 1'b1;
      {reg_write_i, reg_read_i, debug_mode_i} = 3'h0;
      {reg_addr_i, reg_wdata_i, src_level} = 24'h0;
      fail_count = 0;
      cmp_count = 0;
      repeat (16) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      test_registers();
      test_free_running();
      test_sync();
      test_one_shot();
      test_gate_reset();
      test_mono_debug();
      test_reset();
      stop_test();
   end
endmodule : test_period_timer_with_limit_modes
`default_nettype wire
